/* File: pkg/sfs_cfg.svh */
/*
  Register offsets, field positions, reset values and timing
  figures of the safety fault status register bank.
  Assumes it is included by bare name wherever needed.
*/
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define SFS_A_OVSEL 8'h10
`define SFS_A_BASE1 8'h11
`define SFS_A_BASE2 8'h12
`define SFS_A_UV 8'h13
`define SFS_A_OV 8'h14
`define SFS_A_OC 8'h15
`define SFS_A_STATE 8'h16
`define SFS_A_CRCC 8'h18
`define SFS_A_CRCR 8'h19
`define SFS_A_KEY1 8'h20
`define SFS_A_KEY2 8'h21
`define SFS_A_WDT 8'hAD

// ****************************************
// reset values and unlock codes
// ****************************************
`define SFS_R_OVSEL 5'h1F
`define SFS_R_CRCEN 1'h1
`define SFS_KEY1 8'h69
`define SFS_KEY2 8'h96

// ****************************************
// field positions
// ****************************************
`define SFS_B_CRC_START 7
`define SFS_B_CRC_FAIL 6
`define SFS_B_CRC_DONE 5
`define SFS_B_CRC_EN 4
`define SFS_B_BASE_CRC 5
`define SFS_B_WD_EN 7
`define SFS_B_WD_UP 5
`define SFS_B_WD_LO 3
`define SFS_B_WD_LOEN 2
`define SFS_B_WD_ACT 1
`define SFS_B_WD_KICK 0

// ****************************************
// timing
// ****************************************
`define SFS_CLK_MHZ 100
`define SFS_CYC_PER_MS (`SFS_CLK_MHZ * 1000)
`define SFS_WD_UP0_MS 250
`define SFS_WD_UP1_MS 62
`define SFS_WD_UP2_MS 53
`define SFS_WD_LO0_MS 139
`define SFS_WD_LO1_MS 35
`define SFS_WD_LO2_MS 29

`endif

/* File: pkg/sfs_pkg.sv */
/*
  Types of the safety fault status register bank.
  Assumes nothing of its surroundings.
*/
package sfs_pkg;

  // register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfs_reg_req_type;

  // raw fault detector outputs
  typedef struct packed {
    logic [6:0] base;
    logic error_output_pin;
    logic [4:0] uv;
    logic [4:0] ov;
    logic [4:0] oc;
  } sfs_fault_type;

  typedef enum logic [2:0] {
    SFS_CRC_IDLE = 3'b001,
    SFS_CRC_RUN = 3'b010,
    SFS_CRC_CMP = 3'b100
  } sfs_crc_state_type;

endpackage

/* File: hw/sfs_regs.sv */
/*
  Safety fault status register bank: protection selects,
  sticky fault flags, device state, configuration CRC check,
  guest unlock and window watchdog.
  Assumes the serial front end presents one decoded byte
  access per cycle, and that configuration memory answers
  o_cfg_addr combinationally on i_cfg_data.
*/
`timescale 1ns/1ns
`include "sfs_cfg.svh"

module sfs_regs #(
  parameter int P_CYC_PER_MS = `SFS_CYC_PER_MS,
  parameter int P_CFG_BYTES = 7,
  parameter logic [7:0] P_CRC_POLY = 8'h07,
  parameter logic [7:0] P_CRC_INIT = 8'h00
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire sfs_pkg::sfs_reg_req_type i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire sfs_pkg::sfs_fault_type i_fault,
  input wire logic i_fault_mask,
  input wire logic [2:0] i_device_state,
  output logic [$clog2(P_CFG_BYTES)-1:0] o_cfg_addr,
  input wire logic [7:0] i_cfg_data,
  output logic [4:0] o_ov_latch_sel,
  output logic [4:0] o_ov_shutdown,
  output logic o_guest_mode,
  output logic o_device_reset
);

  localparam int AW = $clog2(P_CFG_BYTES);
  localparam int PW = $clog2(P_CYC_PER_MS + 1);

  // ****************************************
  // fault synchroniser
  // ****************************************
  sfs_pkg::sfs_fault_type flt_s1_q;
  sfs_pkg::sfs_fault_type flt_q;

  // detectors are asynchronous, so two stages first
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      flt_s1_q <= '0;
      flt_q <= '0;
    end else begin
      flt_s1_q <= i_fault;
      flt_q <= flt_s1_q;
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  logic wr;
  logic [7:0] wd;
  logic wr_ovsel;
  logic wr_base1;
  logic wr_base2;
  logic wr_crcc;
  logic wr_key1;
  logic wr_key2;
  logic wr_wdt;
  logic rpt;

  assign wr = i_reg_req.wr;
  assign wd = i_reg_req.wdata;
  assign wr_ovsel = wr && (i_reg_req.addr == `SFS_A_OVSEL);
  assign wr_base1 = wr && (i_reg_req.addr == `SFS_A_BASE1);
  assign wr_base2 = wr && (i_reg_req.addr == `SFS_A_BASE2);
  assign wr_crcc = wr && (i_reg_req.addr == `SFS_A_CRCC);
  assign wr_key1 = wr && (i_reg_req.addr == `SFS_A_KEY1);
  assign wr_key2 = wr && (i_reg_req.addr == `SFS_A_KEY2);
  assign wr_wdt = wr && (i_reg_req.addr == `SFS_A_WDT);
  assign rpt = !i_fault_mask;

  // ****************************************
  // overvoltage protection select
  // ****************************************
  logic [4:0] ovsel_q;
  logic [2:0] ovsel_res_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ovsel_q <= `SFS_R_OVSEL;
      ovsel_res_q <= 3'h0;
      o_ov_shutdown <= 5'h00;
    end else begin
      if (wr_ovsel) begin
        ovsel_q <= wd[4:0];
        ovsel_res_q <= wd[7:5];
      end
      // latch-off holds until reset, mask or not
      o_ov_shutdown <= o_ov_shutdown | (flt_q.ov & ovsel_q);
    end
  end

  assign o_ov_latch_sel = ovsel_q;

  // ****************************************
  // base event flags
  // ****************************************
  logic [6:0] base1_q;
  logic base1_res_q;
  logic [1:0] base2_q;
  logic [5:0] base2_res_q;
  logic crc_bad;
  logic wd_fault;
  logic [6:0] base1_set;

  assign base1_set = flt_q.base | {1'b0, crc_bad, 5'h00};

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      base1_q <= 7'h00;
      base1_res_q <= 1'b0;
    end else begin
      if (wr_base1) begin
        base1_res_q <= wd[7];
      end
      base1_q <= (base1_q & ~({7{wr_base1}} & wd[6:0]))
                 | ({7{rpt}} & base1_set);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      base2_q <= 2'h0;
      base2_res_q <= 6'h00;
    end else begin
      if (wr_base2) begin
        base2_res_q <= wd[5:0];
      end
      base2_q <= (base2_q & ~({2{wr_base2}} & wd[7:6]))
                 | ({2{rpt}} & {wd_fault, flt_q.error_output_pin});
    end
  end

  // ****************************************
  // channel event flags
  // ****************************************
  logic [4:0] ch_q [3];
  logic [2:0] ch_res_q [3];
  logic [4:0] ch_set [3];

  assign ch_set[0] = flt_q.uv;
  assign ch_set[1] = flt_q.ov;
  assign ch_set[2] = flt_q.oc;

  // undervoltage, overvoltage, overcurrent, in address order
  for (genvar g = 0; g < 3; g++) begin : g_ch
    logic wr_ch;
    assign wr_ch = wr && (i_reg_req.addr == (`SFS_A_UV + 8'(g)));
    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        ch_q[g] <= 5'h00;
        ch_res_q[g] <= 3'h0;
      end else begin
        if (wr_ch) begin
          ch_res_q[g] <= wd[7:5];
        end
        ch_q[g] <= (ch_q[g] & ~({5{wr_ch}} & wd[4:0]))
                   | ({5{rpt}} & ch_set[g]);
      end
    end
  end

  // ****************************************
  // device state
  // ****************************************
  logic [2:0] state_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= 3'h0;
    end else begin
      state_q <= i_device_state;
    end
  end

  // ****************************************
  // configuration CRC
  // ****************************************
  sfs_pkg::sfs_crc_state_type crc_st_q;
  logic crc_en_q;
  logic crc_done_q;
  logic crc_fail_q;
  logic [3:0] crcc_res_q;
  logic [7:0] crc_acc_q;
  logic [7:0] crc_res_q;
  logic [AW-1:0] idx_q;
  logic crc_start;

  // one byte per cycle, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int b = 0; b < 8; b++) begin
      r = r[7] ? ((r << 1) ^ P_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // start acts only as a pulse
  assign crc_start = wr_crcc && wd[`SFS_B_CRC_START] && crc_en_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      crc_en_q <= `SFS_R_CRCEN;
      crcc_res_q <= 4'h0;
    end else if (wr_crcc) begin
      crc_en_q <= wd[`SFS_B_CRC_EN];
      crcc_res_q <= wd[3:0];
    end
  end

  // calculation sequence
  // last byte holds the stored value to compare against
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      crc_st_q <= sfs_pkg::SFS_CRC_IDLE;
      crc_acc_q <= 8'h00;
      idx_q <= '0;
    end else begin
      case (crc_st_q)
        sfs_pkg::SFS_CRC_IDLE: begin
          if (crc_start) begin
            crc_st_q <= sfs_pkg::SFS_CRC_RUN;
            crc_acc_q <= P_CRC_INIT;
            idx_q <= '0;
          end
        end
        sfs_pkg::SFS_CRC_RUN: begin
          crc_acc_q <= crc_step(crc_acc_q, i_cfg_data);
          idx_q <= idx_q + 1'b1;
          if (idx_q == AW'(P_CFG_BYTES - 2)) begin
            crc_st_q <= sfs_pkg::SFS_CRC_CMP;
          end
        end
        sfs_pkg::SFS_CRC_CMP: begin
          crc_st_q <= sfs_pkg::SFS_CRC_IDLE;
          idx_q <= '0;
        end
        default: begin
          crc_st_q <= sfs_pkg::SFS_CRC_IDLE;
        end
      endcase
      // disabling mid-run abandons the pass
      if (!crc_en_q) begin
        crc_st_q <= sfs_pkg::SFS_CRC_IDLE;
        idx_q <= '0;
      end
    end
  end

  assign crc_bad = (crc_st_q == sfs_pkg::SFS_CRC_CMP)
                   && (crc_acc_q != i_cfg_data);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      crc_done_q <= 1'b0;
      crc_fail_q <= 1'b0;
      crc_res_q <= 8'h00;
    end else if (crc_start) begin
      crc_done_q <= 1'b0;
      crc_fail_q <= 1'b0;
    end else if (crc_st_q == sfs_pkg::SFS_CRC_CMP) begin
      crc_done_q <= 1'b1;
      crc_fail_q <= crc_bad;
      crc_res_q <= crc_acc_q;
    end
  end

  assign o_cfg_addr = idx_q;

  // ****************************************
  // guest unlock
  // ****************************************
  logic [7:0] key1_q;
  logic [7:0] key2_q;
  logic [7:0] key1_d;
  logic [7:0] key2_d;

  assign key1_d = wr_key1 ? wd : key1_q;
  assign key2_d = wr_key2 ? wd : key2_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      key1_q <= 8'h00;
      key2_q <= 8'h00;
      o_guest_mode <= 1'b0;
    end else begin
      key1_q <= key1_d;
      key2_q <= key2_d;
      if (key1_d != `SFS_KEY1 || key2_d != `SFS_KEY2) begin
        o_guest_mode <= 1'b0;
      end else if (wr_key2 && key1_q == `SFS_KEY1) begin
        o_guest_mode <= 1'b1;
      end
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  logic wd_en_q;
  logic [1:0] wd_up_q;
  logic [1:0] wd_lo_q;
  logic wd_loen_q;
  logic wd_act_q;
  logic [PW-1:0] pre_q;
  logic [7:0] ms_q;
  logic [7:0] up_ms;
  logic [7:0] lo_ms;
  logic tick;
  logic kick;
  logic late;
  logic early;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wd_en_q <= 1'b0;
      wd_up_q <= 2'h0;
      wd_lo_q <= 2'h0;
      wd_loen_q <= 1'b0;
      wd_act_q <= 1'b0;
    end else if (wr_wdt) begin
      wd_en_q <= wd[`SFS_B_WD_EN];
      wd_up_q <= wd[`SFS_B_WD_UP +: 2];
      wd_lo_q <= wd[`SFS_B_WD_LO +: 2];
      wd_loen_q <= wd[`SFS_B_WD_LOEN];
      wd_act_q <= wd[`SFS_B_WD_ACT];
    end
  end

  assign up_ms = (wd_up_q == 2'h0) ? 8'(`SFS_WD_UP0_MS) :
                 (wd_up_q == 2'h1) ? 8'(`SFS_WD_UP1_MS) :
                 8'(`SFS_WD_UP2_MS);
  assign lo_ms = (wd_lo_q == 2'h0) ? 8'(`SFS_WD_LO0_MS) :
                 (wd_lo_q == 2'h1) ? 8'(`SFS_WD_LO1_MS) :
                 8'(`SFS_WD_LO2_MS);

  assign kick = wr_wdt && wd[`SFS_B_WD_KICK] && wd_en_q;
  assign tick = (pre_q == PW'(P_CYC_PER_MS - 1));
  assign late = wd_en_q && tick && (ms_q == up_ms - 8'h01);
  assign early = kick && wd_loen_q && (ms_q < lo_ms);
  assign wd_fault = late || early;

  // millisecond grid; resolution one ms, cheap counters
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pre_q <= '0;
      ms_q <= 8'h00;
    end else if (!wd_en_q || kick || late) begin
      pre_q <= '0;
      ms_q <= 8'h00;
    end else if (tick) begin
      pre_q <= '0;
      ms_q <= ms_q + 8'h01;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_device_reset <= 1'b0;
    end else begin
      o_device_reset <= wd_fault && wd_act_q;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [7:0] rd_d;

  // unmapped offsets read zero
  always_comb begin
    rd_d = 8'h00;
    case (i_reg_req.addr)
      `SFS_A_OVSEL: rd_d = {ovsel_res_q, ovsel_q};
      `SFS_A_BASE1: rd_d = {base1_res_q, base1_q};
      `SFS_A_BASE2: rd_d = {base2_q, base2_res_q};
      `SFS_A_UV: rd_d = {ch_res_q[0], ch_q[0]};
      `SFS_A_OV: rd_d = {ch_res_q[1], ch_q[1]};
      `SFS_A_OC: rd_d = {ch_res_q[2], ch_q[2]};
      `SFS_A_STATE: rd_d = {5'h00, state_q};
      `SFS_A_CRCC: rd_d = {1'b0, crc_fail_q, crc_done_q, crc_en_q, crcc_res_q};
      `SFS_A_CRCR: rd_d = crc_res_q;
      `SFS_A_KEY1: rd_d = key1_q;
      `SFS_A_KEY2: rd_d = key2_q;
      `SFS_A_WDT: rd_d = {wd_en_q, wd_up_q, wd_lo_q, wd_loen_q, wd_act_q, 1'b0};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_req.rd;
      if (i_reg_req.rd) begin
        o_reg_rdata <= rd_d;
      end
    end
  end

endmodule

/* File: bench/sfs_regs_monitor.sv */
/*
  Checker of the safety fault status register bank ports.
  Assumes the bind below and the design's synchronous reset.
*/
`timescale 1ns/1ns
module sfs_regs_monitor #(
  parameter int P_CYC_PER_MS = 10,
  parameter int P_CFG_BYTES = 7
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire sfs_pkg::sfs_reg_req_type i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic [$clog2(P_CFG_BYTES)-1:0] o_cfg_addr,
  input wire logic [2:0] i_device_state,
  input wire logic [4:0] o_ov_latch_sel,
  input wire logic [4:0] o_ov_shutdown,
  input wire logic o_guest_mode,
  input wire logic o_device_reset
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // ****************************************
  // read port
  // ****************************************
  read_answer_a: assert property (i_reg_req.rd |=> o_reg_rvalid)
    else $error("read not answered");
  no_stray_a: assert property (!i_reg_req.rd |=> !o_reg_rvalid)
    else $error("answer without read");
  hole_read_a: assert property (i_reg_req.rd && i_reg_req.addr == 8'h17 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  state_read_a: assert property (i_reg_req.rd && i_reg_req.addr == 8'h16 && $stable(i_device_state)
    |=> o_reg_rdata == {5'h00, $past(i_device_state)}) else $error("state read wrong");

  // ****************************************
  // protection, guest, watchdog and config index outputs
  // ****************************************
  ov_select_a: assert property (i_reg_req.wr && i_reg_req.addr == 8'h10
    |=> o_ov_latch_sel == $past(i_reg_req.wdata[4:0])) else $error("select not written");
  latch_sticky_a: assert property (($past(o_ov_shutdown) & ~o_ov_shutdown) == 5'h00)
    else $error("latch-off released");
  guest_exit_a: assert property (i_reg_req.wr && ((i_reg_req.addr == 8'h20 && i_reg_req.wdata != 8'h69)
    || (i_reg_req.addr == 8'h21 && i_reg_req.wdata != 8'h96)) |=> !o_guest_mode) else $error("guest kept");
  guest_entry_a: assert property ($rose(o_guest_mode) |-> $past(i_reg_req.wr)
    && $past(i_reg_req.addr) == 8'h21 && $past(i_reg_req.wdata) == 8'h96) else $error("guest without key");
  reset_pulse_a: assert property (o_device_reset |=> !o_device_reset)
    else $error("reset pulse too long");
  cfg_index_a: assert property (o_cfg_addr < P_CFG_BYTES)
    else $error("config index out of range");

  // main scenarios reached
  cover property ($rose(o_guest_mode));
  cover property (o_device_reset);
  cover property (o_cfg_addr == P_CFG_BYTES - 1);
endmodule

bind sfs_regs sfs_regs_monitor #(.P_CYC_PER_MS(P_CYC_PER_MS), .P_CFG_BYTES(P_CFG_BYTES)) u_mon (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .o_cfg_addr(o_cfg_addr), .i_device_state(i_device_state),
  .o_ov_latch_sel(o_ov_latch_sel), .o_ov_shutdown(o_ov_shutdown), .o_guest_mode(o_guest_mode),
  .o_device_reset(o_device_reset));

/* File: bench/sfs_host_model.sv */
/*
  Host controller model: decoded byte writes and reads.
  Assumes the byte port answers reads one cycle after the take.
*/
`timescale 1ns/1ns
module sfs_host_model (
  input wire logic i_clock,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  output sfs_pkg::sfs_reg_req_type o_req
);
  int gap = 0;
  initial o_req = '0;
  // one write per strobe, released lines show inverse
  task automatic wr(input logic [7:0] a, d);
    repeat (gap) @(posedge i_clock);
    @(posedge i_clock);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // read data taken at the edge that samples the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    @(posedge i_clock);
    d = i_rvalid ? i_rdata : 8'hXX;
  endtask
endmodule

/* File: bench/tb.sv */
/*
  Self-checking bench of the safety fault status register bank.
  Assumes the host model drives the byte port and a 7-byte
  combinational config memory lives here.
*/
`timescale 1ns/1ns
module tb;
  logic i_clock, i_rst_n, i_fault_mask, rvalid, guest, dres;
  sfs_pkg::sfs_fault_type i_fault;
  sfs_pkg::sfs_reg_req_type req;
  logic [2:0] i_device_state, cfg_addr;
  logic [7:0] rdata, v;
  logic [7:0] cfg_mem [7];
  logic [4:0] ov_sel, ov_sd;
  logic [7:0] ra [12] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h20, 8'h21, 8'hAD};
  logic [7:0] rv [12] = '{8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
  int errors, checks_done, seed, n;

  // short millisecond keeps watchdog spans between 290 and 2500 cycles
  sfs_regs #(.P_CYC_PER_MS(10)) DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_req(req),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_fault(i_fault), .i_fault_mask(i_fault_mask),
    .i_device_state(i_device_state), .o_cfg_addr(cfg_addr), .i_cfg_data(cfg_mem[cfg_addr]),
    .o_ov_latch_sel(ov_sel), .o_ov_shutdown(ov_sd), .o_guest_mode(guest), .o_device_reset(dres));
  sfs_host_model host (.i_clock(i_clock), .i_rvalid(rvalid), .i_rdata(rdata), .o_req(req));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // crc8 msb first, poly 07, init 00, over the first k bytes
  function automatic logic [7:0] crc_of(input int k);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < k; i++) begin
      c = c ^ cfg_mem[i];
      for (int b = 0; b < 8; b++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction

  task automatic chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask

  task automatic wait_n(input int k);
    repeat (k) @(posedge i_clock);
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    #200000;
    errors++;
    results();
  end

  initial begin
    seed = 30320;
    i_rst_n = 1'b0;
    i_fault = '0;
    i_fault_mask = 1'b0;
    i_device_state = 3'h0;
    for (int i = 0; i < 7; i++) cfg_mem[i] = $random(seed);
    wait_n(12);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) rchk(ra[i], rv[i]);
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      host.gap = i % 3;
      i_device_state <= v[2:0];
      host.wr(8'h10, v);
      rchk(8'h10, v);
      chk({3'h0, ov_sel}, {3'h0, v[4:0]});
      rchk(8'h16, {5'h00, v[2:0]});
    end
    i_fault.ov <= 5'h1F;
    i_fault.uv <= 5'h10;
    wait_n(4);
    i_fault <= '0;
    wait_n(4);
    chk({3'h0, ov_sd}, {3'h0, v[4:0]});
    rchk(8'h14, 8'h1F);
    host.wr(8'h13, 8'h00);
    rchk(8'h13, 8'h10);
    host.wr(8'h13, 8'hF0);
    rchk(8'h13, 8'hE0);
    i_fault_mask <= 1'b1;
    i_fault.oc <= 5'h01;
    i_fault.base <= 7'h7F;
    wait_n(4);
    i_fault <= '0;
    // mask must outlast the two-stage fault synchroniser
    wait_n(4);
    i_fault_mask <= 1'b0;
    wait_n(1);
    rchk(8'h15, 8'h00);
    i_fault.oc <= 5'h01;
    i_fault.base <= 7'h41;
    i_fault.error_output_pin <= 1'b1;
    wait_n(4);
    host.wr(8'h15, 8'h01);
    rchk(8'h15, 8'h01);
    i_fault <= '0;
    wait_n(4);
    rchk(8'h11, 8'h41);
    rchk(8'h12, 8'h40);
    host.wr(8'h11, 8'h41);
    host.wr(8'h12, 8'h40);
    host.wr(8'h15, 8'h01);
    rchk(8'h11, 8'h00);
    rchk(8'h12, 8'h00);
    rchk(8'h15, 8'h00);
    $display("flags done");
    cfg_mem[6] <= crc_of(6) ^ 8'h01;
    host.wr(8'h18, 8'h90);
    wait_n(10);
    rchk(8'h18, 8'h70);
    rchk(8'h19, crc_of(6));
    rchk(8'h11, 8'h20);
    // bench stores the fresh value before the next check
    cfg_mem[6] <= crc_of(6);
    host.wr(8'h11, 8'h20);
    host.wr(8'h18, 8'h90);
    wait_n(10);
    rchk(8'h18, 8'h30);
    host.wr(8'h18, 8'h00);
    host.wr(8'h18, 8'h80);
    wait_n(10);
    // start refused while disabled, so the old done bit stays
    rchk(8'h18, 8'h20);
    $display("crc done");
    host.wr(8'h20, 8'h69);
    host.wr(8'h21, 8'h96);
    // guest flop sets at the taking edge and is checked one edge later
    wait_n(1);
    chk({7'h0, guest}, 8'h01);
    host.wr(8'h21, 8'h00);
    wait_n(1);
    chk({7'h0, guest}, 8'h00);
    host.wr(8'h20, 8'h00);
    host.wr(8'h21, 8'h96);
    host.wr(8'h20, 8'h69);
    wait_n(1);
    chk({7'h0, guest}, 8'h00);
    $display("guest done");
    host.gap = 0;
    host.wr(8'hAD, 8'hA2);
    n = 0;
    while (dres !== 1'b1 && n < 700) begin
      @(posedge i_clock);
      n++;
    end
    chk({7'h0, n > 615 && n < 630}, 8'h01);
    rchk(8'h12, 8'h80);
    host.wr(8'hAD, 8'h00);
    host.wr(8'h12, 8'h80);
    host.wr(8'hAD, 8'hAC);
    host.wr(8'hAD, 8'hAD);
    rchk(8'hAD, 8'hAC);
    rchk(8'h12, 8'h80);
    host.wr(8'hAD, 8'h00);
    $display("watchdog done");
    results();
  end
endmodule
